// *** common/sat_pkg.sv ***
package sat_pkg;

	// ==========================================================
	// address fields
	localparam int ADDR_W       = 24;
	localparam int PHYS_W       = 21;
	localparam int PAGE_W       = 12;
	localparam int OFFS_W       = 9;
	localparam int DISP_W       = 8;
	localparam int SEG_W        = 7;
	localparam int CTX_W        = 2;
	localparam int CODE_W       = 4;
	localparam int LEN_W        = 8;
	localparam int REG_W        = 12;
	localparam int ROM_W        = 14;
	localparam int SEG_LSB      = 17;
	localparam int DISP_LSB     = 9;
	localparam int OFFS_LSB     = 0;
	localparam int CODE_LSB     = 8;
	localparam int LEN_LSB      = 0;

	// ==========================================================
	// register store geometry
	localparam int NUM_SEGS     = 128;
	localparam int NUM_CTX      = 4;
	localparam int NUM_REGS     = 1024;
	localparam int INDEX_W      = CTX_W + SEG_W + 1;

	// ==========================================================
	// special i/o decode bit positions
	localparam int SIO_ZERO_BIT = 16;
	localparam int SIO_REG_BIT  = 15;
	localparam int SIO_MAP_BIT  = 14;
	localparam int SIO_PICK_BIT = 3;

	// ==========================================================
	// access control codes
	localparam logic [CODE_W-1:0] CODE_STACK_RO = 4'h4;
	localparam logic [CODE_W-1:0] CODE_RO       = 4'h5;
	localparam logic [CODE_W-1:0] CODE_STACK_RW = 4'h6;
	localparam logic [CODE_W-1:0] CODE_RW       = 4'h7;
	localparam logic [CODE_W-1:0] CODE_IO       = 4'h9;
	localparam logic [CODE_W-1:0] CODE_ABSENT   = 4'hc;
	localparam logic [CODE_W-1:0] CODE_SPECIAL  = 4'hf;

	localparam logic [LEN_W:0]    STACK_TOP_SUM = 9'h0ff;
	localparam logic [CTX_W-1:0]  SUPER_CTX     = 2'h0;
	localparam logic              PICK_ORIGIN   = 1'b0;
	localparam logic              PICK_LIMIT    = 1'b1;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		SAT_SPACE_MEM,
		SAT_SPACE_IO,
		SAT_SPACE_SPECIAL
	} sat_space_t;

	typedef enum logic [2:0] {
		SAT_OK,
		SAT_LIMIT,
		SAT_READ_ONLY,
		SAT_ABSENT,
		SAT_INVALID,
		SAT_SIO_UNMAPPED
	} sat_cause_t;

	typedef struct packed {
		logic       valid;
		sat_space_t space;
		logic       read_only;
		logic       stack;
		logic       absent;
	} sat_access_t;

	typedef struct packed {
		logic              valid;
		logic [ADDR_W-1:0] addr;
		logic              write;
		logic              supervisor;
		logic [REG_W-1:0]  wdata;
	} sat_req_t;

	typedef struct packed {
		logic              valid;
		logic [PHYS_W-1:0] phys_addr;
		sat_space_t        space;
		logic              rom_sel;
		logic              reg_sel;
		logic              error;
		sat_cause_t        cause;
		logic [REG_W-1:0]  rdata;
	} sat_resp_t;

	localparam sat_resp_t RESP_RESET = '0;

	function automatic sat_access_t sat_decode_access(input logic [CODE_W-1:0] code);
		sat_access_t a;
		a = '0;
		a.valid = 1'b1;
		a.space = SAT_SPACE_MEM;
		unique case (code)
			CODE_STACK_RO: begin
				a.read_only = 1'b1;
				a.stack = 1'b1;
			end
			CODE_RO:       a.read_only = 1'b1;
			CODE_STACK_RW: a.stack = 1'b1;
			CODE_RW:       a.read_only = 1'b0;
			CODE_IO:       a.space = SAT_SPACE_IO;
			CODE_ABSENT:   a.absent = 1'b1;
			CODE_SPECIAL:  a.space = SAT_SPACE_SPECIAL;
			default:       a.valid = 1'b0;
		endcase
		return a;
	endfunction

endpackage

// *** logic/sat_limit_check.sv ***
`timescale 1ns/100ps

module sat_limit_check
	import sat_pkg::*;
(
	// page under test and segment length
	input  wire logic [DISP_W-1:0] page_disp,
	input  wire logic [LEN_W-1:0]  seg_length,
	input  wire logic              is_stack,
	// result
	output logic                   violation
);

	// ==========================================================
	// length is held in two's complement, so one adder serves both
	logic [LEN_W:0] sum;

	always_comb begin
		sum = {1'b0, page_disp} + {1'b0, seg_length};
		if (is_stack) begin
			// stack grows down from the top page
			violation = (sum < STACK_TOP_SUM);
		end else begin
			violation = sum[LEN_W];
		end
	end

endmodule // sat_limit_check

// *** logic/sat_translator.sv ***
`timescale 1ns/100ps


module sat_translator
	import sat_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// processor request
	input  wire sat_req_t   req,
	// mode and context bits
	input  wire logic       setup_mode,
	input  wire logic       context_sel_low,
	input  wire logic       context_sel_high,
	// translation result
	output sat_resp_t       resp
);

	// ==========================================================
	// address fields
	logic [SEG_W-1:0]   seg_idx;
	logic [DISP_W-1:0]  page_disp;
	logic [OFFS_W-1:0]  byte_offs;
	logic [ROM_W-1:0]   rom_addr;

	always_comb begin
		seg_idx   = req.addr[SEG_LSB +: SEG_W];
		page_disp = req.addr[DISP_LSB +: DISP_W];
		byte_offs = req.addr[OFFS_LSB +: OFFS_W];
		rom_addr  = req.addr[ROM_W-1:0];
	end

	// ==========================================================
	// context selection
	logic [CTX_W-1:0] cur_ctx;

	always_comb begin
		if (req.supervisor) begin
			cur_ctx = SUPER_CTX;
		end else begin
			cur_ctx = {context_sel_high, context_sel_low};
		end
	end

	// ==========================================================
	// register store
	// contents are undefined after power-up; software must load them
	logic [REG_W-1:0]   pair_mem [NUM_REGS];
	logic [INDEX_W-1:0] origin_index;
	logic [INDEX_W-1:0] limit_index;
	logic [INDEX_W-1:0] reg_index;
	logic [REG_W-1:0]   origin_val;
	logic [REG_W-1:0]   limit_val;
	logic [REG_W-1:0]   reg_val;
	logic               reg_pick;

	always_comb begin
		reg_pick     = req.addr[SIO_PICK_BIT];
		origin_index = {cur_ctx, seg_idx, PICK_ORIGIN};
		limit_index  = {cur_ctx, seg_idx, PICK_LIMIT};
		reg_index    = {cur_ctx, seg_idx, reg_pick};
		origin_val   = pair_mem[origin_index];
		limit_val    = pair_mem[limit_index];
		reg_val      = pair_mem[reg_index];
	end

	// ==========================================================
	// limit register fields and access classification
	logic [CODE_W-1:0] access_code;
	logic [LEN_W-1:0]  seg_length;
	sat_access_t       access;

	always_comb begin
		access_code = limit_val[CODE_LSB +: CODE_W];
		seg_length  = limit_val[LEN_LSB +: LEN_W];
		access      = sat_decode_access(access_code);
	end

	// ==========================================================
	// page relocation
	logic [PAGE_W-1:0] phys_page;
	logic [PHYS_W-1:0] mapped_addr;

	always_comb begin
		// origin counts whole pages, so the sum is itself a page number
		phys_page   = origin_val + {{(PAGE_W-DISP_W){1'b0}}, page_disp};
		mapped_addr = {phys_page, byte_offs};
	end

	// ==========================================================
	// limit check
	logic limit_fault;

	// the two's complement length makes the check on the added page
	// equal to a check on the displacement alone
	sat_limit_check u_limit (
		.page_disp  (page_disp),
		.seg_length (seg_length),
		.is_stack   (access.stack),
		.violation  (limit_fault)
	);

	// ==========================================================
	// special i/o decode
	logic direct_sio;
	logic sio_path;
	logic sio_reg_hit;
	logic sio_rom_hit;

	always_comb begin
		// setup with bit 14 low bypasses the map entirely
		direct_sio  = setup_mode && !req.addr[SIO_MAP_BIT];
		sio_path    = direct_sio || (access.valid && access.space == SAT_SPACE_SPECIAL);
		sio_reg_hit = sio_path
			&& !req.addr[SIO_ZERO_BIT]
			&& req.addr[SIO_REG_BIT]
			&& !req.addr[SIO_MAP_BIT];
		sio_rom_hit = sio_path
			&& !req.addr[SIO_REG_BIT]
			&& !req.addr[SIO_MAP_BIT];
	end

	// ==========================================================
	// error classification
	sat_cause_t next_cause;

	always_comb begin
		next_cause = SAT_OK;
		if (direct_sio) begin
			if (!sio_reg_hit && !sio_rom_hit) begin
				next_cause = SAT_SIO_UNMAPPED;
			end
		end else if (!access.valid) begin
			next_cause = SAT_INVALID;
		end else if (access.absent) begin
			next_cause = SAT_ABSENT;
		end else if (access.space == SAT_SPACE_SPECIAL) begin
			// special i/o segments are not length checked
			if (!sio_reg_hit && !sio_rom_hit) begin
				next_cause = SAT_SIO_UNMAPPED;
			end
		end else if (req.write && access.read_only) begin
			next_cause = SAT_READ_ONLY;
		end else if (limit_fault) begin
			next_cause = SAT_LIMIT;
		end
	end

	// ==========================================================
	// result routing
	sat_space_t        next_space;
	logic [PHYS_W-1:0] next_phys;
	logic              next_error;

	always_comb begin
		next_error = (next_cause != SAT_OK);
		if (sio_path) begin
			next_space = SAT_SPACE_SPECIAL;
			next_phys  = {{(PHYS_W-ROM_W){1'b0}}, rom_addr};
		end else begin
			next_space = access.space;
			next_phys  = mapped_addr;
		end
	end

	// ==========================================================
	// register writes, only from the special i/o register window
	logic reg_write;

	always_comb begin
		reg_write = req.valid && req.write && sio_reg_hit && !next_error;
	end

	always_ff @(posedge clk) begin
		if (reg_write) begin
			pair_mem[reg_index] <= req.wdata;
		end
	end

	// ==========================================================
	// response register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			resp <= RESP_RESET;
		end else begin
			resp.valid <= req.valid;
			if (req.valid) begin
				resp.phys_addr <= next_phys;
				resp.space     <= next_space;
				resp.rom_sel   <= sio_rom_hit && !next_error;
				resp.reg_sel   <= sio_reg_hit && !next_error;
				resp.error     <= next_error;
				resp.cause     <= next_cause;
				if (sio_reg_hit && !req.write) begin
					resp.rdata <= reg_val;
				end else begin
					resp.rdata <= '0;
				end
			end
		end
	end

endmodule // sat_translator

// *** verif/sat_translator_props.sv ***
`timescale 1ns/100ps
module sat_translator_props
	import sat_pkg::*;
(
	// clock and reset
	input wire logic      clk,
	input wire logic      rst_n,
	// watched ports
	input wire sat_req_t  req,
	input wire logic      setup_mode,
	input wire logic      context_sel_low,
	input wire logic      context_sel_high,
	input wire sat_resp_t resp
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ==========
	// request kinds
	sequence s_req; req.valid; endsequence
	sequence s_ans; resp.valid; endsequence
	sequence s_dir; req.valid && setup_mode && !req.addr[14]; endsequence
	// ==========
	// checks
	a_answer_next: assert property (s_req |=> s_ans)
		else $error("no answer");
	a_answer_only: assert property (!req.valid |=> !resp.valid)
		else $error("answer without request");
	a_offset_kept: assert property (s_ans ##0 !resp.error
		&& resp.space != SAT_SPACE_SPECIAL |-> resp.phys_addr[8:0] == $past(req.addr[8:0]))
		else $error("offset changed");
	a_direct_path: assert property (s_dir |=> resp.space == SAT_SPACE_SPECIAL
		&& resp.phys_addr == {7'h0, $past(req.addr[13:0])})
		else $error("direct path wrong");
	a_rom_decode: assert property (s_dir ##0 req.addr[15:14] == 2'h0 |=> resp.rom_sel)
		else $error("rom not hit");
	a_reg_decode: assert property (s_dir ##0 req.addr[16:14] == 3'h2 |=> resp.reg_sel)
		else $error("register not hit");
	a_unmapped_err: assert property (s_dir ##0 req.addr[16:14] == 3'h6
		|=> resp.error && resp.cause == SAT_SIO_UNMAPPED)
		else $error("unmapped not refused");
	a_error_cause: assert property (s_ans |-> resp.error == (resp.cause != SAT_OK))
		else $error("error and cause differ");
	a_error_no_sel: assert property (s_ans ##0 resp.error |-> !resp.rom_sel && !resp.reg_sel)
		else $error("select on abort");
	a_rdata_zero: assert property (s_ans ##0 !resp.reg_sel |-> resp.rdata == 12'h0)
		else $error("read data leaks");
endmodule // sat_translator_props

// *** verif/sat_cpu_model.sv ***
`timescale 1ns/100ps
module sat_cpu_model
	import sat_pkg::*;
(
	// clock and answer
	input  wire logic      clk,
	input  wire sat_resp_t resp,
	// request toward translator
	output sat_req_t       req
);
	initial req = '0;
	// ==========
	// one access; the answer has a fixed one-cycle latency
	task automatic access(input logic [ADDR_W-1:0] a, input logic w, input logic s,
		input logic [REG_W-1:0] d, output sat_resp_t r);
		@(posedge clk);
		#1 req = '{1'b1, a, w, s, d};
		@(posedge clk);
		#1 r = resp;
		// released lines flip so a stale address never passes as current
		req = '{1'b0, ~a, ~w, ~s, ~d};
	endtask
endmodule // sat_cpu_model

// *** verif/tb_sat_translator.sv ***
`timescale 1ns/100ps
module tb_sat_translator
	import sat_pkg::*;
;
	logic             clk;
	logic             rst_n;
	logic             setup_mode;
	logic [1:0]       ctx;
	logic [1:0]       c;
	logic             s;
	logic             w;
	logic [23:0]      a;
	sat_req_t         req;
	sat_resp_t        resp;
	sat_resp_t        r;
	logic [REG_W-1:0] sh [NUM_REGS];
	integer           seed = 52701;
	int               n_mismatch = 0;
	int               n_tests = 0;
	int               cyc = 0;

	sat_cpu_model i_sat_cpu_model (.clk(clk), .resp(resp), .req(req));
	sat_translator i_sat_translator (.clk(clk), .rst_n(rst_n), .req(req),
		.setup_mode(setup_mode), .context_sel_low(ctx[0]), .context_sel_high(ctx[1]),
		.resp(resp));

	// ==========
	// expectation from the shadow store
	function automatic logic [38:0] exp_of(input logic [1:0] k, input logic [23:0] x,
		input logic wr, input logic d);
		logic [11:0] l;
		logic [8:0]  sum;
		logic [11:0] rd;
		logic [20:0] p;
		sat_cause_t  e;
		sat_space_t  sp;
		l = d ? 12'hf00 : sh[{k, x[23:17], 1'b1}];
		sum = {1'b0, x[16:9]} + l[7:0];
		p = {sh[{k, x[23:17], 1'b0}] + x[16:9], x[8:0]};
		sp = l[11:8] == CODE_IO ? SAT_SPACE_IO : SAT_SPACE_MEM;
		rd = 12'h0;
		if (!(l[11:8] inside {CODE_STACK_RO, CODE_RO, CODE_STACK_RW, CODE_RW, CODE_IO,
			CODE_ABSENT, CODE_SPECIAL})) e = SAT_INVALID;
		else if (l[11:8] == CODE_ABSENT) e = SAT_ABSENT;
		else if (l[11:8] == CODE_SPECIAL) begin
			sp = SAT_SPACE_SPECIAL;
			p = {7'h0, x[13:0]};
			e = x[16:14] == 3'h2 || x[15:14] == 2'h0 ? SAT_OK : SAT_SIO_UNMAPPED;
			if (x[16:14] == 3'h2 && !wr) rd = sh[{k, x[23:17], x[3]}];
		end
		else if (wr && l[11:9] == 3'h2) e = SAT_READ_ONLY;
		else if (l[8] ? sum[8] : sum < 9'h0ff) e = SAT_LIMIT;
		else e = SAT_OK;
		return {rd, e != SAT_OK, e, e == SAT_OK ? {sp, p} : 23'h0};
	endfunction

	function automatic logic [38:0] got_of(input sat_resp_t q);
		return {q.rdata, q.error, q.cause, q.error ? 23'h0 : {q.space, q.phys_addr}};
	endfunction

	task automatic chk(input logic [38:0] g, input logic [38:0] e);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error at %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic go(input logic d, input logic [REG_W-1:0] wd);
		ctx = c;
		i_sat_cpu_model.access(a, w, s, wd, r);
		chk(got_of(r), exp_of(s ? SUPER_CTX : c, a, w, d));
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// ==========
	// clock and cycle ceiling
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	// ==========
	// main sequence
	initial begin
		rst_n = 1'b0;
		setup_mode = 1'b1;
		ctx = 2'h0;
		repeat (12) @(posedge clk);
		#1 rst_n = 1'b1;
		s = 1'b0;
		w = 1'b1;
		// store is not reset, so every pair of every context is loaded first
		for (int i = 0; i < NUM_REGS; i++) begin
			sh[i] = 12'($random(seed));
			if (i[0] && i[3:2] == 2'h0) sh[i][7:0] = {8{i[4]}};
			c = i[9:8];
			a = {i[7:1], 3'h2, 10'h0, i[0], 3'h0};
			go(1'b1, sh[i]);
		end
		w = 1'b0;
		repeat (300) begin
			{a, c, s} = 27'($random(seed));
			a[14] = 1'b0;
			go(1'b1, 12'h0);
		end
		// page corners 00, 01, fe, ff hit the length boundaries
		repeat (800) begin
			{a, c, s} = 27'($random(seed));
			if (a[0]) a[16:9] = {8{a[1]}} ^ {7'h0, a[2]};
			setup_mode = a[4];
			a[14] = a[14] | a[4];
			w = a[5] && sh[{s ? SUPER_CTX : c, a[23:17], 1'b1}][11:8] != CODE_SPECIAL;
			go(1'b0, 12'($random(seed)));
		end
		tally_and_finish();
	end
endmodule // tb_sat_translator

bind sat_translator sat_translator_props i_sat_translator_props (.clk(clk), .rst_n(rst_n),
	.req(req), .setup_mode(setup_mode), .context_sel_low(context_sel_low),
	.context_sel_high(context_sel_high), .resp(resp));
